/* File: fsp_guard.sv */
// access guard: section rules, stalls, page tracking and fuse loading
`timescale 1ns/1ps
module fsp_guard #(
    parameter int OP_CYCLES = fsp_pkg::OP_CYCLES,
    parameter int PAGE_BYTES = fsp_pkg::PAGE_BYTES
) (
    input wire logic clk,
    input wire logic rst,
    // ============================================================
    // cpu side
    input wire logic [fsp_pkg::FLASH_ADDR_W-1:0] cpuPc,
    input wire logic cpuRead,
    input wire logic [fsp_pkg::FLASH_ADDR_W-1:0] cpuReadAddr,
    input wire logic cpuReadFlash,
    input fsp_pkg::fsp_cmd_t cpuCmd,
    input wire logic [fsp_pkg::PAGE_OFS_W-1:0] bufWriteOfs,
    input wire logic bufWrite,
    input fsp_pkg::fsp_ctrl_t ctrlWrite,
    input wire logic ctrlWriteEn,
    input wire logic vectorTableSelect,
    // ============================================================
    // programming port side
    input fsp_pkg::fsp_cmd_t portCmd,
    input wire logic deviceLocked,
    input wire logic [fsp_pkg::FUSE_COUNT*fsp_pkg::FUSE_W-1:0] fuseArray,
    input wire logic startupDone,
    // ============================================================
    // outputs
    output logic cpuStall,
    output logic readDeny,
    output logic cmdRefused,
    output logic opBusy,
    output fsp_pkg::fsp_cmd_t opActive,
    output logic [PAGE_BYTES-1:0] byteMask,
    output logic pageWhole,
    output logic [fsp_pkg::FLASH_ADDR_W-1:0] vectorBase,
    output fsp_pkg::fsp_ctrl_t ctrlState,
    output logic [fsp_pkg::FUSE_COUNT*fsp_pkg::FUSE_W-1:0] configRegs,
    output fsp_pkg::fsp_bounds_t boundsOut
);
    import fsp_pkg::*;

    typedef enum {
        FSP_ST_IDLE,
        FSP_ST_BUSY
    } fsp_state_t;

    typedef struct packed {
        fsp_state_t st;
        logic [OP_CNT_W-1:0] cnt;
        fsp_cmd_t op;
        logic opStalling;
        logic [PAGE_BYTES-1:0] mask;
        fsp_ctrl_t ctrl;
        logic [FUSE_COUNT*FUSE_W-1:0] cfg;
        logic cfgLoaded;
        logic refused;
    } fsp_guard_state_t;

    localparam logic [OP_CNT_W-1:0] OP_LAST = OP_CNT_W'(OP_CYCLES - 1);

    fsp_guard_state_t s_reg;
    fsp_guard_state_t s_next;
    fsp_bounds_t bounds;
    fsp_region_t pcRegion;
    fsp_region_t rdRegion;
    fsp_region_t tgtRegion;
    fsp_cmd_t req;
    logic allowed;
    logic rdInConcurrent;

    // size fuses live in the two lowest configuration bytes
    fsp_bounds u_bounds (
        .loaderSizeFuse(s_reg.cfg[FUSE_W-1:0]),
        .codeSizeFuse(s_reg.cfg[2*FUSE_W-1:FUSE_W]),
        .bounds(bounds)
    );
    fsp_classify u_pc (
        .addr(cpuPc),
        .bounds(bounds),
        .region(pcRegion)
    );
    fsp_classify u_rd (
        .addr(cpuReadAddr),
        .bounds(bounds),
        .region(rdRegion)
    );
    fsp_classify u_tgt (
        .addr(req.addr),
        .bounds(bounds),
        .region(tgtRegion)
    );

    // ============================================================
    // permission check
    // port has priority over the cpu for the one request slot
    assign req = portCmd.valid ? portCmd : cpuCmd;

    always_comb begin
        allowed = 1'b0;
        if (req.fromPort) begin
            // port writes user row and fuses even on a locked part
            allowed = (req.target == FSP_TGT_USER_ROW_A)
                || (req.target == FSP_TGT_FUSE) || !deviceLocked;
        end else if (req.target == FSP_TGT_FUSE) begin
            allowed = 1'b0;
        end else if (pcRegion == FSP_REG_DATA) begin
            allowed = 1'b0;
        end else begin
            case (req.target)
                FSP_TGT_FLASH: begin
                    case (tgtRegion)
                        FSP_REG_LOADER: allowed = 1'b0;
                        FSP_REG_CODE: allowed = (pcRegion == FSP_REG_LOADER)
                            && !s_reg.ctrl.codeRegionWriteProtect;
                        FSP_REG_DATA: allowed =
                            !s_reg.ctrl.dataRegionWriteProtect;
                        default: allowed = 1'b0;
                    endcase
                    if (req.op == FSP_OP_CHIP_ERASE) begin
                        allowed = 1'b0;
                    end
                end
                FSP_TGT_EEPROM: allowed =
                    !s_reg.ctrl.eepromWriteProtect;
                FSP_TGT_USER_ROW_A: allowed = 1'b1;
                default: allowed = 1'b0;
            endcase
        end
    end

    // ============================================================
    // state update
    always_comb begin
        s_next = s_reg;
        s_next.refused = 1'b0;
        if (!s_reg.cfgLoaded && startupDone) begin
            s_next.cfg = fuseArray;
            s_next.cfgLoaded = 1'b1;
        end
        if (ctrlWriteEn) begin
            // read protect only settable from loader code, never cleared
            if (pcRegion == FSP_REG_LOADER && ctrlWrite.loaderReadProtect) begin
                s_next.ctrl.loaderReadProtect = 1'b1;
            end
            s_next.ctrl.eepromWriteProtect = ctrlWrite.eepromWriteProtect;
            s_next.ctrl.dataRegionWriteProtect =
                ctrlWrite.dataRegionWriteProtect;
            s_next.ctrl.codeRegionWriteProtect =
                ctrlWrite.codeRegionWriteProtect;
        end
        case (s_reg.st)
            FSP_ST_IDLE: begin
                if (bufWrite) begin
                    s_next.mask[bufWriteOfs] = 1'b1;
                end
                if (req.valid && req.op != FSP_OP_NONE) begin
                    if (allowed) begin
                        s_next.st = FSP_ST_BUSY;
                        s_next.cnt = OP_LAST;
                        s_next.op = req;
                        s_next.opStalling = (req.target == FSP_TGT_FLASH)
                            && (req.addr >= STALL_REGION_START);
                    end else begin
                        s_next.refused = 1'b1;
                    end
                end
            end
            FSP_ST_BUSY: begin
                if (s_reg.cnt == '0) begin
                    s_next.st = FSP_ST_IDLE;
                    s_next.op.valid = 1'b0;
                    s_next.opStalling = 1'b0;
                    s_next.mask = '0;
                end else begin
                    s_next.cnt = s_reg.cnt - OP_CNT_W'(1);
                end
            end
            default: s_next.st = FSP_ST_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_reg <= '{st: FSP_ST_IDLE, cnt: '0, op: '0, opStalling: 1'b0,
                mask: '0, ctrl: '0, cfg: '0,
                cfgLoaded: 1'b0, refused: 1'b0};
        end else begin
            s_reg <= s_next;
        end
    end

    // ============================================================
    // stall and outputs
    always_comb begin
        rdInConcurrent = cpuReadFlash && (cpuReadAddr < STALL_REGION_START);
        cpuStall = 1'b0;
        if (s_reg.st == FSP_ST_BUSY) begin
            if (s_reg.opStalling) begin
                cpuStall = 1'b1;
            end else if (s_reg.op.target == FSP_TGT_FLASH
                    || s_reg.op.target == FSP_TGT_USER_ROW_A) begin
                // stalling region stays readable while concurrent busy
                cpuStall = cpuRead && rdInConcurrent;
            end else begin
                cpuStall = cpuRead && !cpuReadFlash;
            end
        end
    end

    // protection acts from the first cycle the pc is outside the loader
    assign readDeny = s_reg.ctrl.loaderReadProtect
        && pcRegion != FSP_REG_LOADER
        && cpuRead && cpuReadFlash && rdRegion == FSP_REG_LOADER;
    assign cmdRefused = s_reg.refused;
    assign opBusy = (s_reg.st == FSP_ST_BUSY);
    assign opActive = s_reg.op;
    // eeprom touches marked bytes only; flash and user row whole page
    assign byteMask = (s_reg.op.target == FSP_TGT_EEPROM) ?
        s_reg.mask : '1;
    assign pageWhole = (s_reg.op.target != FSP_TGT_EEPROM);
    assign vectorBase = vectorTableSelect ? FLASH_FIRST_ADDR :
        (bounds.codePresent ? bounds.loaderEnd : FLASH_FIRST_ADDR);
    assign ctrlState = s_reg.ctrl;
    assign configRegs = s_reg.cfg;
    assign boundsOut = bounds;
endmodule : fsp_guard

/* File: fsp_pkg.sv */
// package of constants and carrier types for the flash section protection block
// ============================================================
package fsp_pkg;
    // ============================================================
    // geometry
    localparam int FLASH_ADDR_W = 14;
    localparam int EE_ADDR_W = 9;
    localparam int PAGE_BYTES = 64;
    localparam int PAGE_OFS_W = 6;
    localparam int FUSE_UNIT_SHIFT = 8;
    localparam int FUSE_W = 8;
    localparam logic [FUSE_W-1:0] LOADER_SIZE_DEFAULT = 8'h00;
    localparam logic [FUSE_W-1:0] CODE_SIZE_DEFAULT = 8'h00;
    localparam logic [FLASH_ADDR_W-1:0] FLASH_FIRST_ADDR = 14'h0000;
    localparam logic [FLASH_ADDR_W-1:0] FLASH_LAST_ADDR = 14'h3FFF;
    // concurrent read region is the low 12 KB
    localparam logic [FLASH_ADDR_W-1:0] STALL_REGION_START = 14'h3000;
    localparam int FUSE_COUNT = 4;
    localparam int OP_CYCLES = 16;
    localparam int OP_CNT_W = 12;

    // ============================================================
    // enumerations
    typedef enum logic [1:0] {
        FSP_REG_LOADER,
        FSP_REG_CODE,
        FSP_REG_DATA
    } fsp_region_t;

    typedef enum logic [2:0] {
        FSP_TGT_FLASH,
        FSP_TGT_EEPROM,
        FSP_TGT_USER_ROW_A,
        FSP_TGT_FUSE,
        FSP_TGT_NONE
    } fsp_target_t;

    typedef enum logic [2:0] {
        FSP_OP_WRITE,
        FSP_OP_ERASE,
        FSP_OP_ERASE_WRITE,
        FSP_OP_CHIP_ERASE,
        FSP_OP_NONE
    } fsp_op_t;

    // ============================================================
    // carriers
    typedef struct packed {
        logic [FLASH_ADDR_W-1:0] loaderEnd;
        logic [FLASH_ADDR_W-1:0] code_end_addr;
        logic codePresent;
        logic dataPresent;
    } fsp_bounds_t;

    typedef struct packed {
        logic loaderReadProtect;
        logic eepromWriteProtect;
        logic dataRegionWriteProtect;
        logic codeRegionWriteProtect;
    } fsp_ctrl_t;

    typedef struct packed {
        logic valid;
        fsp_target_t target;
        fsp_op_t op;
        logic [FLASH_ADDR_W-1:0] addr;
        logic fromPort;
    } fsp_cmd_t;
endpackage : fsp_pkg

/* File: fsp_bounds.sv */
// region boundary decoder from the two size fuses
`timescale 1ns/1ps
module fsp_bounds (
    input wire logic [fsp_pkg::FUSE_W-1:0] loaderSizeFuse,
    input wire logic [fsp_pkg::FUSE_W-1:0] codeSizeFuse,
    output fsp_pkg::fsp_bounds_t bounds
);
    import fsp_pkg::*;

    logic [FUSE_W-1:0] lsz;
    logic [FUSE_W-1:0] csz;
    logic [FUSE_W+FUSE_UNIT_SHIFT:0] lEnd;
    logic [FUSE_W+FUSE_UNIT_SHIFT:0] cEnd;
    localparam logic [FUSE_W+FUSE_UNIT_SHIFT:0] FLASH_SIZE =
        17'(FLASH_LAST_ADDR) + 17'h00001;

    always_comb begin
        // an end past the last flash address falls back to the default
        // fuse; an end of exactly the flash size would wrap to zero
        lsz = ({1'b0, loaderSizeFuse, 8'h00} >= FLASH_SIZE) ?
            LOADER_SIZE_DEFAULT : loaderSizeFuse;
        csz = ({1'b0, codeSizeFuse, 8'h00} >= FLASH_SIZE) ?
            CODE_SIZE_DEFAULT : codeSizeFuse;
        lEnd = {1'b0, lsz, 8'h00};
        cEnd = {1'b0, csz, 8'h00};
        bounds.codePresent = 1'b0;
        bounds.dataPresent = 1'b0;
        bounds.loaderEnd = FLASH_LAST_ADDR;
        bounds.code_end_addr = FLASH_LAST_ADDR;
        if (lsz == 8'h00) begin
            bounds.loaderEnd = FLASH_LAST_ADDR;
        end else if (csz == 8'h00) begin
            bounds.loaderEnd = lEnd[FLASH_ADDR_W-1:0];
            bounds.code_end_addr = FLASH_LAST_ADDR;
            bounds.codePresent = 1'b1;
        end else if (csz <= lsz) begin
            bounds.loaderEnd = lEnd[FLASH_ADDR_W-1:0];
            bounds.code_end_addr = lEnd[FLASH_ADDR_W-1:0];
            bounds.dataPresent = 1'b1;
        end else begin
            bounds.loaderEnd = lEnd[FLASH_ADDR_W-1:0];
            bounds.code_end_addr = cEnd[FLASH_ADDR_W-1:0];
            bounds.codePresent = 1'b1;
            bounds.dataPresent = (cEnd != FLASH_SIZE);
        end
    end
endmodule : fsp_bounds

/* File: fsp_classify.sv */
// maps a flash address to its logical region
`timescale 1ns/1ps
module fsp_classify (
    input wire logic [fsp_pkg::FLASH_ADDR_W-1:0] addr,
    input fsp_pkg::fsp_bounds_t bounds,
    output fsp_pkg::fsp_region_t region
);
    import fsp_pkg::*;

    // loader end marks the first byte past the loader; zero-size is all loader
    always_comb begin
        if (!bounds.codePresent && !bounds.dataPresent) begin
            region = FSP_REG_LOADER;
        end else if (addr < bounds.loaderEnd) begin
            region = FSP_REG_LOADER;
        end else if (bounds.codePresent && (addr < bounds.code_end_addr
                || !bounds.dataPresent)) begin
            region = FSP_REG_CODE;
        end else begin
            region = FSP_REG_DATA;
        end
    end
endmodule : fsp_classify

/* File: fsp_guard_assertions.sv */
// concurrent checks on the ports of the flash section protection guard
`timescale 1ns/1ps
module fsp_guard_assertions #(
    parameter int OP_CYCLES = 16
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [13:0] cpuPc,
    input wire logic cpuRead,
    input wire logic [13:0] cpuReadAddr,
    input wire logic cpuReadFlash,
    input fsp_pkg::fsp_cmd_t cpuCmd,
    input fsp_pkg::fsp_cmd_t portCmd,
    input wire logic vectorTableSelect,
    input wire logic cpuStall,
    input wire logic readDeny,
    input wire logic cmdRefused,
    input wire logic opBusy,
    input fsp_pkg::fsp_cmd_t opActive,
    input wire logic [13:0] vectorBase,
    input fsp_pkg::fsp_ctrl_t ctrlState,
    input fsp_pkg::fsp_bounds_t boundsOut
);
    import fsp_pkg::*;
    // ============================================================
    // helpers
    logic [11:0] busyCnt_reg;
    logic flashOp, hiOp, loRd;
    always_ff @(posedge clk) begin
        busyCnt_reg <= (rst || !opBusy) ? 12'h000 : busyCnt_reg + 12'h001;
    end
    always_comb begin
        flashOp = opBusy && opActive.target == FSP_TGT_FLASH;
        hiOp = opActive.addr >= STALL_REGION_START;
        loRd = cpuRead && cpuReadFlash && cpuReadAddr < STALL_REGION_START;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // idle cpu request with no port request competing for the slot
    sequence sReq(fsp_target_t t);
        cpuCmd.valid && cpuCmd.target == t && cpuCmd.op != FSP_OP_NONE
            && !portCmd.valid && !opBusy;
    endsequence
    // ============================================================
    // assertions
    AST_BUSY_LEN: assert property ($fell(opBusy) |->
        busyCnt_reg == OP_CYCLES) else $error("busy length");
    AST_REFUSE_ONE: assert property (cmdRefused |=>
        !cmdRefused && !opBusy) else $error("refusal pulse");
    AST_LOADER_WR: assert property (sReq(FSP_TGT_FLASH) ##0
        cpuCmd.addr < boundsOut.loaderEnd |=> cmdRefused)
        else $error("loader write taken");
    AST_EE_WP: assert property (sReq(FSP_TGT_EEPROM) ##0
        ctrlState.eepromWriteProtect |=> cmdRefused)
        else $error("protected eeprom taken");
    AST_STALL_ALL: assert property (flashOp && hiOp |-> cpuStall)
        else $error("no stall");
    AST_SAME_REG: assert property (flashOp && !hiOp && loRd |-> cpuStall)
        else $error("same region read ran");
    AST_CONC_OK: assert property (opBusy && cpuRead && cpuReadFlash
        && (opActive.target == FSP_TGT_USER_ROW_A || flashOp && !hiOp)
        && !loRd && cpuPc >= STALL_REGION_START |-> !cpuStall)
        else $error("needless stall");
    AST_VECTOR: assert property (boundsOut.codePresent |-> vectorBase ==
        (vectorTableSelect ? FLASH_FIRST_ADDR : boundsOut.loaderEnd))
        else $error("vector base");
    AST_READ_PROT: assert property (ctrlState.loaderReadProtect
        && cpuRead && cpuReadFlash && cpuReadAddr < boundsOut.loaderEnd
        && cpuPc >= boundsOut.loaderEnd |-> readDeny)
        else $error("loader read passed");
endmodule : fsp_guard_assertions

bind fsp_guard fsp_guard_assertions #(.OP_CYCLES(OP_CYCLES)) u_chk (
    .clk, .rst, .cpuPc, .cpuRead, .cpuReadAddr, .cpuReadFlash, .cpuCmd,
    .portCmd, .vectorTableSelect, .cpuStall, .readDeny, .cmdRefused,
    .opBusy, .opActive, .vectorBase, .ctrlState, .boundsOut);

/* File: fsp_cpu_model.sv */
// cpu core model: fetches, reads and self-programming requests
`timescale 1ns/1ps
module fsp_cpu_model (
    input wire logic clk,
    input wire logic cpuStall,
    input wire logic readDeny,
    output logic [13:0] cpuPc,
    output logic cpuRead,
    output logic [13:0] cpuReadAddr,
    output logic cpuReadFlash,
    output fsp_pkg::fsp_cmd_t cpuCmd,
    output logic bufWrite,
    output logic [5:0] bufWriteOfs,
    output fsp_pkg::fsp_ctrl_t ctrlWrite,
    output logic ctrlWriteEn
);
    import fsp_pkg::*;
    int nHang = 0;
    initial begin
        {cpuPc, cpuRead, cpuReadAddr, cpuReadFlash} = '0;
        {cpuCmd, bufWrite, bufWriteOfs, ctrlWrite, ctrlWriteEn} = '0;
    end
    // ============================================================
    // a stalled cpu keeps its read up until the wait state clears or 64 cycles pass
    task automatic rd(input logic [13:0] pc, a, output logic st, dn);
        @(negedge clk);
        {cpuPc, cpuReadAddr, cpuReadFlash, cpuRead} = {pc, a, 2'b11};
        #1;
        st = cpuStall;
        dn = readDeny;
        for (int i = 0; i < 64 && cpuStall; i++) @(negedge clk);
        if (cpuStall) nHang++;
        @(negedge clk);
        cpuRead = 1'b0;
    endtask : rd
    task automatic cmd(input logic [13:0] pc, input fsp_target_t t,
        input fsp_op_t o, input logic [13:0] a);
        @(negedge clk);
        cpuPc = pc;
        bufWrite = (t == FSP_TGT_EEPROM);
        bufWriteOfs = a[5:0];
        @(negedge clk);
        bufWrite = 1'b0;
        cpuCmd = '{1'b1, t, o, a, 1'b0};
        @(negedge clk);
        cpuCmd.valid = 1'b0;
    endtask : cmd
    task automatic ctl(input logic [13:0] pc, input fsp_ctrl_t v);
        @(negedge clk);
        {cpuPc, ctrlWrite, ctrlWriteEn} = {pc, v, 1'b1};
        @(negedge clk);
        ctrlWriteEn = 1'b0;
    endtask : ctl
endmodule : fsp_cpu_model

/* File: flash_section_protection_tb_top.sv */
// self-checking bench for the flash section protection guard
`timescale 1ns/1ps
module flash_section_protection_tb_top;
    import fsp_pkg::*;
    logic clk = 1'b0, rst = 1'b1, vectorTableSelect = 1'b0;
    logic deviceLocked = 1'b0, startupDone = 1'b0;
    logic [31:0] fuseArray = '0;
    fsp_cmd_t portCmd = '0;
    logic [13:0] cpuPc, cpuReadAddr, vectorBase;
    logic cpuRead, cpuReadFlash, bufWrite, ctrlWriteEn;
    logic cpuStall, readDeny, cmdRefused, opBusy;
    logic pageWhole;
    logic [63:0] byteMask;
    logic [5:0] bufWriteOfs;
    logic [31:0] configRegs;
    fsp_cmd_t cpuCmd;
    fsp_ctrl_t ctrlWrite, ctrlState;
    fsp_bounds_t boundsOut;
    int n_mismatch = 0, num_checks = 0, seed = 32'h57fbc040;
    logic [15:0] fc [6] = '{16'h0005, 16'h0400, 16'h0804, 16'h0408,
        16'h4008, 16'h0460};
    logic [13:0] pcs [3] = '{14'h0100, 14'h0500, 14'h1000};
    logic [13:0] fad [3] = '{14'h0200, 14'h0600, 14'h3400};
    // short op keeps the run brief; every expectation follows it
    fsp_guard #(.OP_CYCLES(12)) DUT (.clk, .rst, .cpuPc, .cpuRead,
        .cpuReadAddr, .cpuReadFlash, .cpuCmd, .bufWriteOfs, .bufWrite,
        .ctrlWrite, .ctrlWriteEn, .vectorTableSelect, .portCmd,
        .deviceLocked, .fuseArray, .startupDone, .cpuStall, .readDeny,
        .cmdRefused, .opBusy, .opActive(), .byteMask, .pageWhole,
        .vectorBase, .ctrlState, .configRegs, .boundsOut);
    fsp_cpu_model cpu (.clk, .cpuStall, .readDeny, .cpuPc, .cpuRead,
        .cpuReadAddr, .cpuReadFlash, .cpuCmd, .bufWrite, .bufWriteOfs,
        .ctrlWrite, .ctrlWriteEn);
    initial forever #5 clk = ~clk;
    // ============================================================
    // helpers
    task automatic chk1(input logic g, e, input string m);
        num_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("Error at %0t: %s", $time, m);
        end
    endtask : chk1
    task automatic chkW(input logic [31:0] g, e, input string m);
        num_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("Error at %0t: %s", $time, m);
        end
    endtask : chkW
    task automatic summarize;
        n_mismatch += cpu.nHang;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : summarize
    task automatic idle;
        for (int i = 0; i < 100 && opBusy !== 1'b0; i++) @(negedge clk);
        if (opBusy !== 1'b0) begin
            chk1(1'b1, 1'b0, "busy timeout");
            summarize();
        end
    endtask : idle
    task automatic boot(input logic [7:0] ls, cs);
        @(negedge clk);
        {rst, startupDone} = 2'b10;
        fuseArray = {16'($random(seed)), cs, ls};
        repeat (8) @(negedge clk);
        rst = 1'b0;
        chkW(configRegs, 0, "config reset");
        chk1(opBusy, 1'b0, "busy reset");
        @(negedge clk);
        startupDone = 1'b1;
        repeat (2) @(negedge clk);
        chkW(configRegs, fuseArray, "fuse copy");
    endtask : boot
    task automatic port(input fsp_target_t t);
        @(negedge clk);
        portCmd = '{1'b1, t, FSP_OP_WRITE, 14'h0000, 1'b1};
        @(negedge clk);
        portCmd.valid = 1'b0;
        chk1(opBusy, 1'b1, "port write");
        idle();
    endtask : port
    function automatic fsp_bounds_t expB(input logic [7:0] ls, cs);
        fsp_bounds_t b;
        if ({ls, 8'h00} > FLASH_LAST_ADDR) ls = LOADER_SIZE_DEFAULT;
        if ({cs, 8'h00} > FLASH_LAST_ADDR) cs = CODE_SIZE_DEFAULT;
        b.loaderEnd = 14'({ls, 8'h00});
        b.code_end_addr = 14'({cs, 8'h00});
        b.codePresent = ls != 0 && (cs == 0 || cs > ls);
        b.dataPresent = ls != 0 && cs != 0;
        return b;
    endfunction : expB
    // ============================================================
    // scenarios
    initial begin
        logic st, dn, ok;
        logic [7:0] ls, cs;
        logic [31:0] r;
        logic [13:0] a;
        logic [63:0] bm;
        fsp_bounds_t e;
        for (int i = 0; i < 7; i++) begin
            r = $random(seed);
            ls = i < 6 ? fc[i][15:8] : {2'b00, r[5:0]};
            cs = i < 6 ? fc[i][7:0] : {2'b00, r[13:8]};
            boot(ls, cs);
            e = expB(ls, cs);
            chk1(boundsOut.codePresent, e.codePresent, "code");
            chk1(boundsOut.dataPresent, e.dataPresent, "data");
            if (e.codePresent || e.dataPresent) begin
                chkW(boundsOut.loaderEnd, e.loaderEnd, "loader end");
            end
            if (e.codePresent && e.dataPresent) begin
                chkW(boundsOut.code_end_addr, e.code_end_addr, "code end");
            end
        end
        $display("test sections done");
        boot(8'h04, 8'h08);
        chkW(vectorBase, 14'h0400, "vector code");
        @(negedge clk);
        vectorTableSelect = 1'b1;
        #1 chkW(vectorBase, 14'h0000, "vector loader");
        for (int x = 0; x < 15; x++) begin
            ok = x / 5 < 2 && x % 5 > x / 5;
            a = x % 5 < 3 ? fad[x % 5] : 14'($random(seed)) & 14'h01FF;
            // eeprom marks one byte only; flash and user row go whole page
            bm = x % 5 == 3 ? 64'h1 << a[5:0] : {64{1'b1}};
            cpu.cmd(pcs[x / 5], x % 5 < 3 ? FSP_TGT_FLASH : x % 5 == 3 ?
                FSP_TGT_EEPROM : FSP_TGT_USER_ROW_A, fsp_op_t'(x % 3), a);
            chk1(opBusy, ok, "write taken");
            chk1(cmdRefused, !ok, "write refused");
            if (ok) chk1(pageWhole, x % 5 != 3, "page whole");
            if (ok) chk1(byteMask === bm, 1'b1, "byte mask");
            cpu.rd(14'h3100, x % 5 == 2 ? 14'h3100 : 14'h3200, st, dn);
            if (ok && x % 5 > 1) chk1(st, x % 5 == 2, "stall");
            idle();
        end
        cpu.cmd(14'h0500, FSP_TGT_FLASH, FSP_OP_ERASE, 14'h1000);
        cpu.rd(14'h3100, 14'h3200, st, dn);
        chk1(st, 1'b0, "concurrent read");
        cpu.rd(14'h3100, 14'h1000, st, dn);
        chk1(st, 1'b1, "same region read");
        idle();
        $display("test sections access done");
        cpu.cmd(14'h0100, FSP_TGT_FUSE, FSP_OP_WRITE, 14'h0000);
        chk1(cmdRefused, 1'b1, "cpu fuse");
        port(FSP_TGT_FUSE);
        deviceLocked = 1'b1;
        port(FSP_TGT_USER_ROW_A);
        deviceLocked = 1'b0;
        $display("test port done");
        for (int i = 0; i < 3; i++) begin
            cpu.ctl(14'h0100, fsp_ctrl_t'(4'h1 << i));
            chkW(ctrlState, 4'h1 << i, "protect bits");
            cpu.cmd(14'h0100, i == 2 ? FSP_TGT_EEPROM : FSP_TGT_FLASH,
                FSP_OP_WRITE, i == 1 ? 14'h1000 : 14'h0600 >> (i * 2));
            chk1(cmdRefused, 1'b1, "protected write");
        end
        cpu.ctl(14'h0500, 4'h8);
        chk1(ctrlState.loaderReadProtect, 1'b0, "protect from code");
        cpu.ctl(14'h0100, 4'h8);
        chk1(ctrlState.loaderReadProtect, 1'b1, "protect set");
        cpu.rd(14'h0100, 14'h0200, st, dn);
        chk1(dn, 1'b0, "loader reads itself");
        cpu.rd(14'h0500, 14'h0200, st, dn);
        chk1(dn, 1'b1, "loader read blocked");
        $display("test protect done");
        summarize();
    end
endmodule : flash_section_protection_tb_top
